// [cpc_consts.svh]
// Summary of operation
// - Mode 11 keeps the pump running whatever the supply level.
// - Mode 10 runs the pump only while the supply is below the threshold.
// - Mode 01 runs the pump while a peripheral is on and supply is low.
// - The peripheral enable for mode 01 is the converter on bit.
// - The mode resets to 00, and mode 00 keeps the pump off.
// - Oscillator select 1 clocks the pump from its own oscillator.
// - Select 0 uses the RC oscillator, or the divided clock while go is set.
// - The threshold status bit reads 1 above the threshold, 0 below.
// - The ready bit reads 1 only when the pump is on and has settled.
// - The request bit reads 1 while a peripheral requests the pump.
// - Mode is bits 7:6, select bit 5, status bits 2:0; all reset to 0.
`ifndef CPC_CONSTS_SVH
`define CPC_CONSTS_SVH

`define CPC_ADDR_W 12
`define CPC_DIV_W 6
`define CPC_REG_INDEX 10'h20D
`define CPC_REG_ADDR {`CPC_REG_INDEX, 2'h0}
`define CPC_REG_RESET 8'h00

`define CPC_MODE_HI 7
`define CPC_MODE_LO 6
`define CPC_OSEL_BIT 5
`define CPC_REQ_BIT 2
`define CPC_THR_BIT 1
`define CPC_RDY_BIT 0

`define CPC_RESP_OKAY 2'h0
`define CPC_RESP_SLVERR 2'h2
`define CPC_SYNC_STAGES 3

`endif

// [cpc_pkg.sv]
`include "cpc_consts.svh"

package cpc_pkg;

    typedef enum logic [1:0] {
        CPC_MODE_OFF,
        CPC_MODE_PERIPH,
        CPC_MODE_AUTO,
        CPC_MODE_ON
    } cpc_mode_e;

    typedef enum logic [1:0] {
        CPC_SRC_RC,
        CPC_SRC_DIV,
        CPC_SRC_INT
    } cpc_clk_src_e;

    typedef logic [`CPC_DIV_W-1:0] cpc_div_t;
    typedef logic [`CPC_ADDR_W-1:0] cpc_addr_t;

endpackage : cpc_pkg

// [cpc_sync.sv]
`timescale 1ns/1ps

module cpc_sync #(
    parameter int W = 2
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } cpc_sync_s;

    cpc_sync_s s_reg;
    cpc_sync_s s_next;

    // meta feeds only the second stage, never any logic
    always_comb begin
        s_next = s_reg;
        s_next.meta = d;
        s_next.stable = s_reg.meta;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg <= '0;
        end else if (ce) begin
            s_reg <= s_next;
        end
    end

    assign q = s_reg.stable;

endmodule : cpc_sync

// [cpc_top.sv]
`timescale 1ns/1ps
`include "cpc_consts.svh"

module cpc_top (
    // clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // axi4-lite write address
    input wire logic awvalid,
    output logic awready,
    input wire cpc_pkg::cpc_addr_t awaddr,
    input wire logic [2:0] awprot,
    // axi4-lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // axi4-lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // axi4-lite read address
    input wire logic arvalid,
    output logic arready,
    input wire cpc_pkg::cpc_addr_t araddr,
    input wire logic [2:0] arprot,
    // axi4-lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // analog pump side, asynchronous
    input wire logic supply_above_raw,
    input wire logic pump_steady_raw,
    // converter side, same clock
    input wire logic converter_on_bit,
    input wire logic converter_go_bit,
    input wire cpc_pkg::cpc_div_t converter_clock_divider,
    // pump control
    output logic pump_run,
    output cpc_pkg::cpc_clk_src_e pump_clk_src,
    output cpc_pkg::cpc_div_t pump_clk_div
);
    import cpc_pkg::*;

    typedef struct packed {
        cpc_mode_e mode;
        logic osel;
        logic pump_on;
        logic steady;
        logic request;
        logic thr;
        cpc_clk_src_e clk_src;
        cpc_div_t div;
        logic awready;
        logic aw_got;
        cpc_addr_t aw_addr;
        logic wready;
        logic w_got;
        logic [7:0] w_data;
        logic w_lane0;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
    } cpc_state_s;

    localparam cpc_state_s CPC_RESET = '{
        mode: CPC_MODE_OFF,
        osel: 1'b0,
        pump_on: 1'b0,
        steady: 1'b0,
        request: 1'b0,
        thr: 1'b0,
        clk_src: CPC_SRC_RC,
        div: '0,
        awready: 1'b1,
        aw_got: 1'b0,
        aw_addr: '0,
        wready: 1'b1,
        w_got: 1'b0,
        w_data: 8'h00,
        w_lane0: 1'b0,
        bvalid: 1'b0,
        bresp: `CPC_RESP_OKAY,
        arready: 1'b1,
        rvalid: 1'b0,
        rdata: 8'h00,
        rresp: `CPC_RESP_OKAY
    };

    cpc_state_s s_reg;
    cpc_state_s s_next;
    logic [1:0] sync_q;
    logic thr_sync;
    logic rdy_sync;
    logic [7:0] reg_view;

    // comparator and settle flag come from the analog clock-free world
    cpc_sync #(
        .W(2)
    ) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .d({pump_steady_raw, supply_above_raw}),
        .q(sync_q)
    );

    assign thr_sync = sync_q[0];
    assign rdy_sync = sync_q[1];

    // register image; bits 4:3 unimplemented and read 0
    always_comb begin
        reg_view = `CPC_REG_RESET;
        reg_view[`CPC_MODE_HI:`CPC_MODE_LO] = s_reg.mode;
        reg_view[`CPC_OSEL_BIT] = s_reg.osel;
        reg_view[`CPC_REQ_BIT] = s_reg.request;
        reg_view[`CPC_THR_BIT] = s_reg.thr;
        reg_view[`CPC_RDY_BIT] = s_reg.steady;
    end

    always_comb begin
        s_next = s_reg;

        // run decision, one cycle behind its inputs
        unique case (s_reg.mode)
            CPC_MODE_OFF: begin
                s_next.pump_on = 1'b0;
            end
            CPC_MODE_PERIPH: begin
                s_next.pump_on = converter_on_bit && !thr_sync;
            end
            CPC_MODE_AUTO: begin
                s_next.pump_on = !thr_sync;
            end
            CPC_MODE_ON: begin
                s_next.pump_on = 1'b1;
            end
        endcase

        // go switches to the faster divided clock only while converting
        if (s_reg.osel) begin
            s_next.clk_src = CPC_SRC_INT;
        end else if (converter_go_bit) begin
            s_next.clk_src = CPC_SRC_DIV;
        end else begin
            s_next.clk_src = CPC_SRC_RC;
        end
        s_next.div = converter_clock_divider;

        s_next.thr = thr_sync;
        // a stale settle flag from the analog side is masked while off
        s_next.steady = rdy_sync && s_reg.pump_on;
        s_next.request = converter_on_bit;

        // write channels, taken in either order
        if (awvalid && s_reg.awready) begin
            s_next.aw_got = 1'b1;
            s_next.aw_addr = awaddr;
        end
        if (wvalid && s_reg.wready) begin
            s_next.w_got = 1'b1;
            s_next.w_data = wdata[7:0];
            s_next.w_lane0 = wstrb[0];
        end
        if (s_reg.bvalid && bready) begin
            s_next.bvalid = 1'b0;
        end
        if (s_reg.aw_got && s_reg.w_got && !s_reg.bvalid) begin
            s_next.aw_got = 1'b0;
            s_next.w_got = 1'b0;
            s_next.bvalid = 1'b1;
            if (s_reg.aw_addr == `CPC_REG_ADDR) begin
                s_next.bresp = `CPC_RESP_OKAY;
                // status bits are not writable
                if (s_reg.w_lane0) begin
                    s_next.mode = cpc_mode_e'(
                        s_reg.w_data[`CPC_MODE_HI:`CPC_MODE_LO]);
                    s_next.osel = s_reg.w_data[`CPC_OSEL_BIT];
                end
            end else begin
                s_next.bresp = `CPC_RESP_SLVERR;
            end
        end
        s_next.awready = !s_next.aw_got && !s_next.bvalid;
        s_next.wready = !s_next.w_got && !s_next.bvalid;

        // read channel, one outstanding read
        if (s_reg.rvalid && rready) begin
            s_next.rvalid = 1'b0;
        end
        if (arvalid && s_reg.arready) begin
            s_next.rvalid = 1'b1;
            if (araddr == `CPC_REG_ADDR) begin
                s_next.rdata = reg_view;
                s_next.rresp = `CPC_RESP_OKAY;
            end else begin
                s_next.rdata = 8'h00;
                s_next.rresp = `CPC_RESP_SLVERR;
            end
        end
        s_next.arready = !s_next.rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg <= CPC_RESET;
        end else if (ce) begin
            s_reg <= s_next;
        end
    end

    assign awready = s_reg.awready;
    assign wready = s_reg.wready;
    assign bvalid = s_reg.bvalid;
    assign bresp = s_reg.bresp;
    assign arready = s_reg.arready;
    assign rvalid = s_reg.rvalid;
    assign rdata = {24'h000000, s_reg.rdata};
    assign rresp = s_reg.rresp;
    assign pump_run = s_reg.pump_on;
    assign pump_clk_src = s_reg.clk_src;
    assign pump_clk_div = s_reg.div;

    // checks
    default clocking cpc_cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence cpc_aw_take;
        awvalid && awready && ce;
    endsequence

    sequence cpc_w_take;
        wvalid && wready && ce;
    endsequence

    sequence cpc_both_take;
        cpc_aw_take and cpc_w_take;
    endsequence

    a_mode_off_idle: assert property (
        ce && s_reg.mode == CPC_MODE_OFF |=> !pump_run
    ) else $error("pump runs in mode 00");

    a_mode_on_runs: assert property (
        ce && s_reg.mode == CPC_MODE_ON |=> pump_run
    ) else $error("pump stopped in mode 11");

    a_auto_follow: assert property (
        ce && s_reg.mode == CPC_MODE_AUTO
        |=> pump_run == !$past(thr_sync)
    ) else $error("auto mode ignores supply level");

    a_periph_gate: assert property (
        ce && s_reg.mode == CPC_MODE_PERIPH
        |=> pump_run == ($past(converter_on_bit) && !$past(thr_sync))
    ) else $error("peripheral mode gating wrong");

    a_osc_internal: assert property (
        ce && s_reg.osel |=> pump_clk_src == CPC_SRC_INT
    ) else $error("internal oscillator not chosen");

    a_osc_converter: assert property (
        ce && !s_reg.osel |=> pump_clk_src ==
            ($past(converter_go_bit) ? CPC_SRC_DIV : CPC_SRC_RC)
    ) else $error("converter clock source wrong");

    a_thr_path: assert property (
        ce ##1 ce ##1 ce |=> s_reg.thr == $past(supply_above_raw, 3)
    ) else $error("threshold status not three cycles behind pin");

    a_ready_off: assert property (
        ce && !pump_run |=> !s_reg.steady
    ) else $error("ready set while pump off");

    a_request_flag: assert property (
        ce |=> s_reg.request == $past(converter_on_bit)
    ) else $error("request flag does not follow peripheral");

    a_write_resp: assert property (
        cpc_both_take ##1 ce |=> bvalid
    ) else $error("no write response two cycles after take");

    a_reserved_zero: assert property (
        rvalid |-> rdata[4:3] == 2'h0 && rdata[31:8] == 24'h000000
    ) else $error("unimplemented bits read nonzero");

    a_status_ro: assert property (
        ce && s_reg.aw_got && s_reg.w_got && !bvalid
        |=> s_reg.thr == $past(thr_sync)
    ) else $error("write disturbed a status bit");

endmodule : cpc_top

// [tb_charge_pump_control.sv]
`timescale 1ns/1ps
`include "cpc_consts.svh"

module tb_charge_pump_control;
    import cpc_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic ce = 1'b1;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, pump_run;
    cpc_addr_t awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic [3:0] wstrb = '0;
    logic [1:0] bresp, rresp;
    logic supply_above_raw = 1'b0, pump_steady_raw = 1'b0;
    logic converter_on_bit = 1'b0, converter_go_bit = 1'b0;
    cpc_div_t converter_clock_divider = '0, pump_clk_div;
    cpc_clk_src_e pump_clk_src;
    int errors = 0, cmp_count = 0;
    logic [15:0] lf = 16'h8F91;

    cpc_top dut (
        .aclk(aclk), .aresetn(aresetn), .ce(ce),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
        .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata),
        .rresp(rresp), .supply_above_raw(supply_above_raw),
        .pump_steady_raw(pump_steady_raw),
        .converter_on_bit(converter_on_bit),
        .converter_go_bit(converter_go_bit),
        .converter_clock_divider(converter_clock_divider),
        .pump_run(pump_run), .pump_clk_src(pump_clk_src),
        .pump_clk_div(pump_clk_div)
    );

    initial begin
        forever #2.5 aclk = ~aclk;
    end

    function automatic logic [31:0] rnd();
        lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
        return {lf, lf ^ 16'hA5A5};
    endfunction : rnd

    function automatic logic exp_run(logic [1:0] m, logic hi, logic on);
        case (m)
            2'h3: return 1'b1;
            2'h2: return !hi;
            2'h1: return on && !hi;
            default: return 1'b0;
        endcase
    endfunction : exp_run

    function automatic cpc_clk_src_e exp_src(logic sel, logic go);
        if (sel) begin
            return CPC_SRC_INT;
        end
        return go ? CPC_SRC_DIV : CPC_SRC_RC;
    endfunction : exp_src

    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic wr(input cpc_addr_t a, input logic [31:0] d,
                      input logic [3:0] s, output logic [1:0] r);
        int n;
        r = 2'h3;
        @(posedge aclk);
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) begin
                r = bresp;
                bready <= 1'b0;
                break;
            end
        end
        chk("write done", 32'h0, n == 50);
    endtask : wr

    task automatic rd(input cpc_addr_t a, output logic [31:0] d,
                      output logic [1:0] r);
        int n;
        d = '1;
        r = 2'h3;
        @(posedge aclk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                break;
            end
        end
        chk("read done", 32'h0, n == 50);
    endtask : rd

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : report_and_stop

    // the whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge aclk);
        errors++;
        $display("mismatch watchdog expected finish seen timeout");
        report_and_stop();
    end

    initial begin
        logic [1:0] r;
        logic [31:0] d, q;
        logic [1:0] m;
        logic sel, st, ex;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`CPC_REG_ADDR, d, r);
        chk("reset image", 32'h0, d);
        chk("reset run", 32'h0, pump_run);
        $display("test reset done");
        // every mode, select, level and enable; low bits of data random
        for (int i = 0; i < 32; i++) begin
            q = rnd();
            m = i[4:3];
            sel = i[2];
            wr(`CPC_REG_ADDR, {q[31:8], m, sel, q[4:0]}, 4'hF, r);
            chk("write resp", `CPC_RESP_OKAY, r);
            q = rnd();
            supply_above_raw <= i[1];
            converter_on_bit <= i[0];
            converter_go_bit <= q[0];
            pump_steady_raw <= q[1];
            converter_clock_divider <= q[13:8];
            // enough for the synchroniser plus the output flop
            repeat (6) @(posedge aclk);
            ex = exp_run(m, i[1], i[0]);
            st = q[1] & ex;
            chk("pump run", ex, pump_run);
            chk("clock source", exp_src(sel, q[0]), pump_clk_src);
            chk("divider", q[13:8], pump_clk_div);
            rd(`CPC_REG_ADDR, d, r);
            chk("status", {m, sel, 2'h0, i[0], i[1], st}, d);
        end
        $display("test modes done");
        wr(`CPC_REG_ADDR, 32'h0, 4'hE, r);
        chk("masked resp", `CPC_RESP_OKAY, r);
        wr(12'h830, 32'h0, 4'hF, r);
        chk("unmapped wresp", `CPC_RESP_SLVERR, r);
        rd(12'h830, d, r);
        chk("unmapped rresp", `CPC_RESP_SLVERR, r);
        chk("unmapped rdata", 32'h0, d);
        rd(`CPC_REG_ADDR, d, r);
        chk("mode kept", 32'h7, d[7:5]);
        $display("test refusals done");
        // clock enable low must freeze the synchroniser and the run flop
        wr(`CPC_REG_ADDR, 32'h80, 4'h1, r);
        chk("auto resp", `CPC_RESP_OKAY, r);
        supply_above_raw <= 1'b1;
        repeat (6) @(posedge aclk);
        chk("auto high run", 32'h0, pump_run);
        ce <= 1'b0;
        supply_above_raw <= 1'b0;
        repeat (6) @(posedge aclk);
        chk("frozen run", 32'h0, pump_run);
        ce <= 1'b1;
        repeat (6) @(posedge aclk);
        chk("thawed run", 32'h1, pump_run);
        $display("test clock enable done");
        @(posedge aclk);
        aresetn <= 1'b0;
        @(posedge aclk);
        aresetn <= 1'b1;
        rd(`CPC_REG_ADDR, d, r);
        chk("rereset mode", 32'h0, d[7:5]);
        chk("rereset run", 32'h0, pump_run);
        $display("test second reset done");
        report_and_stop();
    end
endmodule : tb_charge_pump_control
